// ===== verilog/aofmt_pkg.sv
// shared constants for the output-format and test-pattern block
package aofmt_pkg;

  // register indices; byte address is four times the index
  localparam logic [7:0] AOFMT_IDX_FORMAT = 8'h0D;
  localparam logic [7:0] AOFMT_IDX_SCRAMBLE = 8'h12;
  localparam logic [7:0] AOFMT_IDX_PAT_CTRL = 8'h13;
  localparam logic [7:0] AOFMT_IDX_PAT0_LOW = 8'h14;
  localparam logic [7:0] AOFMT_IDX_PAT_MID = 8'h15;
  localparam logic [7:0] AOFMT_IDX_PAT1_HIGH = 8'h16;
  localparam logic [7:0] AOFMT_IDX_STAT_LOW = 8'h20;
  localparam logic [7:0] AOFMT_IDX_STAT_HIGH = 8'h21;
  localparam int AOFMT_ADDR_LSB = 2;
  localparam int AOFMT_IDX_W = 8;

  // reset values
  localparam logic [15:0] AOFMT_RST_FORMAT = 16'h2002;
  localparam logic [15:0] AOFMT_RST_SCRAMBLE = 16'h0002;
  localparam logic [15:0] AOFMT_RST_PAT_CTRL = 16'h0000;
  localparam logic [15:0] AOFMT_RST_PAT0_LOW = 16'h0000;
  localparam logic [15:0] AOFMT_RST_PAT_MID = 16'h0000;
  localparam logic [15:0] AOFMT_RST_PAT1_HIGH = 16'h0000;

  // field positions
  localparam int AOFMT_CODING_BIT = 13;
  localparam int AOFMT_GAIN_LSB = 7;
  localparam int AOFMT_XOR_BIT = 3;
  localparam int AOFMT_STEP_LSB = 4;
  localparam int AOFMT_SEL_LSB = 2;
  localparam int AOFMT_INSERT_BIT = 1;
  localparam int AOFMT_STAT_PHASE_BIT = 8;
  localparam int AOFMT_STAT_GAIN_BIT = 9;
  localparam int AOFMT_STAT_INSERT_BIT = 10;
  localparam logic [1:0] AOFMT_GAIN_ALL_ON = 2'h3;

  // widths
  localparam int AOFMT_REG_W = 16;
  localparam int AOFMT_RES_W = 18;
  localparam int AOFMT_PAT_W = 24;
  localparam int AOFMT_NCH = 4;

  typedef enum logic [1:0] {
    AOFMT_SEL_FIXED0,
    AOFMT_SEL_FIXED0_ALIAS,
    AOFMT_SEL_RAMP,
    AOFMT_SEL_ALTERNATE
  } aofmt_sel_e;

endpackage : aofmt_pkg

// ===== verilog/aofmt_cfg_if.sv
// configuration and pattern signals shared by the block's own modules
`timescale 1ns/1ps
interface aofmt_cfg_if;
  import aofmt_pkg::*;
  logic two_comp;
  logic scramble;
  logic insert;
  aofmt_sel_e select;
  logic [3:0] ramp_step;
  logic [AOFMT_PAT_W-1:0] word0;
  logic [AOFMT_PAT_W-1:0] word1;
  logic [AOFMT_PAT_W-1:0] pattern;
  logic alt_phase;

  modport ctrl (
    output two_comp, scramble, insert, select, ramp_step, word0, word1,
    input pattern, alt_phase
  );
  modport gen (
    input insert, select, ramp_step, word0, word1,
    output pattern, alt_phase
  );
  modport coder (
    input two_comp, scramble
  );
endinterface : aofmt_cfg_if

// ===== verilog/aofmt_coder.sv
// per-channel output coding and scrambling of one conversion result
`timescale 1ns/1ps
module aofmt_coder
  import aofmt_pkg::*;
#(
  parameter int RES_W = AOFMT_RES_W,
  parameter int OUT_W = AOFMT_PAT_W
) (
  aofmt_cfg_if.coder cfg,
  input wire logic [RES_W-1:0] raw,
  output logic [OUT_W-1:0] word
);

  logic [RES_W-1:0] coded;

  // raw code arrives offset binary; two's complement is the msb inverted
  always_comb begin
    coded = raw;
    if (cfg.two_comp) begin  // [R1]
      coded[RES_W-1] = ~raw[RES_W-1];
    end
    if (cfg.scramble) begin  // [R4]
      coded = coded ^ {RES_W{coded[0]}};
    end
    // sign extension keeps two's-complement words numerically valid
    if (cfg.two_comp) begin
      word = {{(OUT_W-RES_W){coded[RES_W-1]}}, coded};
    end else begin
      word = {{(OUT_W-RES_W){1'b0}}, coded};
    end
  end

endmodule : aofmt_coder

// ===== verilog/aofmt_patgen.sv
// test pattern generator for the converter A channel group
`timescale 1ns/1ps
module aofmt_patgen
  import aofmt_pkg::*;
#(
  parameter int PAT_W = AOFMT_PAT_W
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic advance,
  aofmt_cfg_if.gen cfg
);

  typedef struct packed {
    logic [PAT_W-1:0] ramp;
    logic phase;
  } aofmt_gen_s;

  aofmt_gen_s st_reg;
  aofmt_gen_s st_next;

  always_comb begin
    st_next = st_reg;
    // ramp and phase restart from zero whenever their mode is not live
    if (!cfg.insert || cfg.select != AOFMT_SEL_RAMP) begin
      st_next.ramp = '0;
    end else if (advance) begin
      st_next.ramp = st_reg.ramp + PAT_W'({cfg.ramp_step} + 5'h01);  // [R5] [R13]
    end
    if (!cfg.insert || cfg.select != AOFMT_SEL_ALTERNATE) begin
      st_next.phase = 1'b0;
    end else if (advance) begin
      st_next.phase = ~st_reg.phase;  // [R13]
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  always_comb begin
    case (cfg.select)
      AOFMT_SEL_FIXED0: cfg.pattern = cfg.word0;  // [R6]
      AOFMT_SEL_FIXED0_ALIAS: cfg.pattern = cfg.word0;  // [R6]
      AOFMT_SEL_RAMP: cfg.pattern = st_reg.ramp;  // [R7]
      AOFMT_SEL_ALTERNATE: cfg.pattern = st_reg.phase ? cfg.word1 : cfg.word0;  // [R8]
      default: cfg.pattern = cfg.word0;
    endcase
  end

  assign cfg.alt_phase = st_reg.phase;

endmodule : aofmt_patgen

// ===== verilog/aofmt_top.sv
// output-word conditioning and test-pattern insertion with an apb register file
//
// Functional notes
// (R1) Each result is straight binary when the coding bit is 0 and two's complement when 1, reset 1.
// (R2) Software writes every reserved field with its reset value, two in the low format/scramble bits.
// (R3) The global gain calibration field disables calibration at 0 and enables it at 3.
// (R4) With scramble on, every result bit is XORed with that result's lsb; off, it passes unchanged.
// (R5) The ramp advances per step by the four-bit step field plus one.
// (R6) Pattern select 0 or 1 sends fixed word 0 on channels 1 to 4.
// (R7) Pattern select 2 sends a digital ramp on channels 1 to 4.
// (R8) Pattern select 3 alternates fixed word 0 and fixed word 1 on channels 1 to 4.
// (R9) Insert bit 0 sends conversion results, insert bit 1 sends the selected pattern.
// (R10) Bits 15:0 of fixed word 0 come from a 16-bit read-write register reset to zero.
// (R11) Bits 23:16 of fixed word 0 sit in the low byte of the next register, word 1 bits 7:0 above.
// (R12) Bits 23:8 of fixed word 1 come from a separate 16-bit register reset to zero.
// (R13) Alternate mode swaps words on successive samples and the ramp wraps at 24 bits.
//
// Register access over APB was chosen for this implementation.
`timescale 1ns/1ps
module aofmt_top
  import aofmt_pkg::*;
#(
  parameter int RES_W = AOFMT_RES_W,
  parameter int PAT_W = AOFMT_PAT_W,
  parameter int NCH = AOFMT_NCH
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic samp_valid,
  input wire logic [NCH*RES_W-1:0] samp_data,
  output logic out_valid,
  output logic [NCH*PAT_W-1:0] out_data,
  output logic gain_cal_on
);

  typedef struct packed {
    logic [AOFMT_REG_W-1:0] format;
    logic [AOFMT_REG_W-1:0] scramble;
    logic [AOFMT_REG_W-1:0] pat_ctrl;
    logic [AOFMT_REG_W-1:0] pat0_low;
    logic [AOFMT_REG_W-1:0] pat_mid;
    logic [AOFMT_REG_W-1:0] pat1_high;
    logic [31:0] rdata;
    logic slverr;
    logic ovalid;
    logic [NCH*PAT_W-1:0] odata;
    logic gain_on;
  } aofmt_top_s;

  aofmt_top_s st_reg;
  aofmt_top_s st_next;

  aofmt_cfg_if cfg ();

  logic [AOFMT_IDX_W-1:0] idx;
  logic setup_phase;
  logic access_write;
  logic mapped;
  logic [31:0] read_mux;
  logic [NCH*PAT_W-1:0] coded_words;

  // byte lanes above the 16-bit registers carry nothing
  function automatic logic [AOFMT_REG_W-1:0] merge_lanes(
    input logic [AOFMT_REG_W-1:0] old_val,
    input logic [31:0] wdata,
    input logic [3:0] strb
  );
    logic [AOFMT_REG_W-1:0] res;
    res = old_val;
    if (strb[0]) begin
      res[7:0] = wdata[7:0];
    end
    if (strb[1]) begin
      res[15:8] = wdata[15:8];
    end
    return res;
  endfunction : merge_lanes

  assign idx = paddr[AOFMT_ADDR_LSB +: AOFMT_IDX_W];
  assign setup_phase = psel && !penable;
  assign access_write = psel && penable && pwrite;

  // register fields routed to the generator and coders
  assign cfg.two_comp = st_reg.format[AOFMT_CODING_BIT];  // [R1]
  assign cfg.scramble = st_reg.scramble[AOFMT_XOR_BIT];  // [R4]
  assign cfg.insert = st_reg.pat_ctrl[AOFMT_INSERT_BIT];
  assign cfg.select = aofmt_sel_e'(st_reg.pat_ctrl[AOFMT_SEL_LSB +: 2]);
  assign cfg.ramp_step = st_reg.pat_ctrl[AOFMT_STEP_LSB +: 4];  // [R5]
  assign cfg.word0 = {st_reg.pat_mid[7:0], st_reg.pat0_low};  // [R10] [R11]
  assign cfg.word1 = {st_reg.pat1_high, st_reg.pat_mid[15:8]};  // [R11] [R12]

  aofmt_patgen #(
    .PAT_W(PAT_W)
  ) u_patgen (
    .pclk(pclk),
    .presetn(presetn),
    .advance(samp_valid),
    .cfg(cfg.gen)
  );

  genvar ch;
  generate
    for (ch = 0; ch < NCH; ch = ch + 1) begin : g_coder
      aofmt_coder #(
        .RES_W(RES_W),
        .OUT_W(PAT_W)
      ) u_coder (
        .cfg(cfg.coder),
        .raw(samp_data[ch*RES_W +: RES_W]),
        .word(coded_words[ch*PAT_W +: PAT_W])
      );
    end
  endgenerate

  // address decode and read-back
  always_comb begin
    mapped = 1'b1;
    read_mux = 32'h0000_0000;
    case (idx)
      AOFMT_IDX_FORMAT: read_mux[15:0] = st_reg.format;
      AOFMT_IDX_SCRAMBLE: read_mux[15:0] = st_reg.scramble;
      AOFMT_IDX_PAT_CTRL: read_mux[15:0] = st_reg.pat_ctrl;
      AOFMT_IDX_PAT0_LOW: read_mux[15:0] = st_reg.pat0_low;
      AOFMT_IDX_PAT_MID: read_mux[15:0] = st_reg.pat_mid;
      AOFMT_IDX_PAT1_HIGH: read_mux[15:0] = st_reg.pat1_high;
      AOFMT_IDX_STAT_LOW: read_mux[15:0] = cfg.pattern[15:0];
      AOFMT_IDX_STAT_HIGH: begin
        read_mux[7:0] = cfg.pattern[PAT_W-1:16];
        read_mux[AOFMT_STAT_PHASE_BIT] = cfg.alt_phase;
        read_mux[AOFMT_STAT_GAIN_BIT] = st_reg.gain_on;
        read_mux[AOFMT_STAT_INSERT_BIT] = cfg.insert;
      end
      default: mapped = 1'b0;
    endcase
    // a nonzero low address bit is a misaligned word access
    if (paddr[AOFMT_ADDR_LSB-1:0] != 2'h0) begin
      mapped = 1'b0;
    end
  end

  always_comb begin
    st_next = st_reg;
    // read data and error are captured in setup so they come from flops
    if (setup_phase) begin
      st_next.rdata = pwrite ? 32'h0000_0000 : read_mux;
      st_next.slverr = !mapped;
    end
    // reserved bits are plain storage; software keeps them at reset values [R2]
    if (access_write && mapped) begin
      case (idx)
        AOFMT_IDX_FORMAT: st_next.format = merge_lanes(st_reg.format, pwdata, pstrb);
        AOFMT_IDX_SCRAMBLE: st_next.scramble = merge_lanes(st_reg.scramble, pwdata, pstrb);
        AOFMT_IDX_PAT_CTRL: st_next.pat_ctrl = merge_lanes(st_reg.pat_ctrl, pwdata, pstrb);
        AOFMT_IDX_PAT0_LOW: begin
          st_next.pat0_low = merge_lanes(st_reg.pat0_low, pwdata, pstrb);  // [R10]
        end
        AOFMT_IDX_PAT_MID: begin
          st_next.pat_mid = merge_lanes(st_reg.pat_mid, pwdata, pstrb);  // [R11]
        end
        AOFMT_IDX_PAT1_HIGH: begin
          st_next.pat1_high = merge_lanes(st_reg.pat1_high, pwdata, pstrb);  // [R12]
        end
        default: st_next.pat_ctrl = st_reg.pat_ctrl;
      endcase
    end
    // values 1 and 2 are undefined; only the all-on code enables
    st_next.gain_on = (st_reg.format[AOFMT_GAIN_LSB +: 2] == AOFMT_GAIN_ALL_ON);  // [R3]
    st_next.ovalid = samp_valid;
    if (samp_valid) begin
      if (cfg.insert) begin
        st_next.odata = {NCH{cfg.pattern}};  // [R9]
      end else begin
        st_next.odata = coded_words;  // [R9]
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_reg.format <= AOFMT_RST_FORMAT;
      st_reg.scramble <= AOFMT_RST_SCRAMBLE;
      st_reg.pat_ctrl <= AOFMT_RST_PAT_CTRL;
      st_reg.pat0_low <= AOFMT_RST_PAT0_LOW;
      st_reg.pat_mid <= AOFMT_RST_PAT_MID;
      st_reg.pat1_high <= AOFMT_RST_PAT1_HIGH;
      st_reg.rdata <= 32'h0000_0000;
      st_reg.slverr <= 1'b0;
      st_reg.ovalid <= 1'b0;
      st_reg.odata <= '0;
      st_reg.gain_on <= 1'b0;
    end else begin
      st_reg <= st_next;
    end
  end

  // zero-wait slave: every access completes in its first access cycle
  assign pready = 1'b1;
  assign prdata = st_reg.rdata;
  assign pslverr = st_reg.slverr && psel && penable;
  assign out_valid = st_reg.ovalid;
  assign out_data = st_reg.odata;
  assign gain_cal_on = st_reg.gain_on;

endmodule : aofmt_top

// ===== tb/aofmt_chk.sv
// port-level assertions for the output-format and test-pattern block
`timescale 1ns/1ps
module aofmt_chk
  import aofmt_pkg::*;
#(
  parameter int RES_W = AOFMT_RES_W,
  parameter int PAT_W = AOFMT_PAT_W,
  parameter int NCH = AOFMT_NCH
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic samp_valid,
  input wire logic [NCH*RES_W-1:0] samp_data,
  input wire logic out_valid,
  input wire logic [NCH*PAT_W-1:0] out_data,
  input wire logic gain_cal_on
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  gain_follow_a: assert property (
    psel && penable && pwrite && paddr == 12'h034 && pstrb[1:0] == 2'h3
    |-> ##2 gain_cal_on == ($past(pwdata[8:7], 2) == 2'h3)) else $error("gain flag wrong");
  gain_hold_a: assert property (
    !(psel && penable && pwrite) [*2] |=> $stable(gain_cal_on)) else $error("gain moved");
  valid_pulse_a: assert property (samp_valid |=> out_valid) else $error("no out_valid");
  valid_idle_a: assert property (!samp_valid |=> !out_valid) else $error("stray valid");
  data_hold_a: assert property (!samp_valid |=> $stable(out_data)) else $error("data moved");
  bad_addr_a: assert property (
    psel && penable && paddr[1:0] != 2'h0 |-> pslverr) else $error("missing error");
  good_addr_a: assert property (
    psel && penable && paddr inside {12'h034, 12'h048, 12'h04C, 12'h050, 12'h054, 12'h058}
    |-> !pslverr && pready) else $error("bad answer");
  err_gate_a: assert property (!(psel && penable) |-> !pslverr) else $error("stray error");
  rdata_top_a: assert property (prdata[31:16] == 16'h0000) else $error("rdata high");
endmodule : aofmt_chk

bind aofmt_top aofmt_chk #(.RES_W(RES_W), .PAT_W(PAT_W), .NCH(NCH)) i_chk (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .samp_valid(samp_valid), .samp_data(samp_data),
  .out_valid(out_valid), .out_data(out_data), .gain_cal_on(gain_cal_on));

// ===== tb/aofmt_host.sv
// host capture model taking each output word on its valid pulse
`timescale 1ns/1ps
module aofmt_host
  import aofmt_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic out_valid,
  input wire logic [AOFMT_NCH*AOFMT_PAT_W-1:0] out_data,
  output logic got,
  output logic [AOFMT_NCH*AOFMT_PAT_W-1:0] cap
);
  // only the pulse qualifies the word; between pulses the data is not trusted
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      got <= 1'b0;
      cap <= '0;
    end else begin
      got <= out_valid;
      if (out_valid) cap <= out_data;
    end
  end
endmodule : aofmt_host

// ===== tb/testbench.sv
// self-checking bench for the output-format and test-pattern block
`timescale 1ns/1ps
module testbench;
  import aofmt_pkg::*;
  localparam logic [11:0] A_FMT = {2'b00, AOFMT_IDX_FORMAT, 2'b00};
  localparam logic [11:0] A_SCR = {2'b00, AOFMT_IDX_SCRAMBLE, 2'b00};
  localparam logic [11:0] A_PC = {2'b00, AOFMT_IDX_PAT_CTRL, 2'b00};
  localparam logic [11:0] A_P0 = {2'b00, AOFMT_IDX_PAT0_LOW, 2'b00};
  localparam logic [11:0] A_PM = {2'b00, AOFMT_IDX_PAT_MID, 2'b00};
  localparam logic [11:0] A_P1 = {2'b00, AOFMT_IDX_PAT1_HIGH, 2'b00};
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0] paddr = '0;
  logic [31:0] pwdata = '0, prdata, rd, t;
  logic [31:0] seed = 32'h7F0C;
  logic [3:0] pstrb = 4'hF, step = '0;
  logic pready, pslverr, out_valid, gain_cal_on, got, err, tc, xr, ph;
  logic samp_valid = 1'b0, ins = 1'b0;
  logic [71:0] samp_data = '0;
  logic [95:0] out_data, cap;
  logic [95:0] q[$];
  logic [23:0] w0, w1, ramp;
  logic [1:0] sel = '0;
  int fails = 0, n_compared = 0;
  always #25 pclk = ~pclk;
  aofmt_top i_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .samp_valid(samp_valid), .samp_data(samp_data),
    .out_valid(out_valid), .out_data(out_data), .gain_cal_on(gain_cal_on));
  aofmt_host i_host (.pclk(pclk), .presetn(presetn), .out_valid(out_valid),
    .out_data(out_data), .got(got), .cap(cap));
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : rnd
  // scramble acts on the 18-bit result; extension to 24 bits comes after it
  function automatic logic [23:0] cod(input logic [17:0] r);
    logic [17:0] c;
    c = tc ? {~r[17], r[16:0]} : r;
    if (xr) begin
      c = c ^ {18{c[0]}};
    end
    return tc ? {{6{c[17]}}, c} : {6'h00, c};
  endfunction : cod
  task automatic chk(input logic [95:0] g, input logic [95:0] x, input string m);
    n_compared++;
    if (g !== x) begin
      fails++;
      $display("wrong value at %0t: %s", $time, m);
    end
  endtask : chk
  // one idle edge after each transfer keeps psel from being driven twice at one edge
  task automatic apb(input logic w, input logic [11:0] a, input logic [15:0] d,
      input logic [3:0] s);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= {16'h0000, d};
    pstrb <= s;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 100);
    if (pready !== 1'b1) begin
      fails++;
      complete_run();
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : apb
  task automatic rdc(input logic [11:0] a, input logic [15:0] x);
    apb(1'b0, a, 16'h0000, 4'hF);
    chk(96'(rd), 96'(x), "register read");
  endtask : rdc
  task automatic send(input int n);
    logic [95:0] d, e;
    logic [23:0] p;
    for (int i = 0; i < n; i++) begin
      d = {rnd(), rnd(), rnd()};
      p = (sel == 2'h2) ? ramp : (sel == 2'h3 && ph) ? w1 : w0;
      for (int c = 0; c < 4; c++) e[c*24 +: 24] = ins ? p : cod(d[c*18 +: 18]);
      if (sel == 2'h2) ramp = ramp + step + 24'h1;
      ph = ~ph;
      q.push_back(e);
      samp_valid <= 1'b1;
      samp_data <= d[71:0];
      @(posedge pclk);
    end
    samp_valid <= 1'b0;
    repeat (3) @(posedge pclk);
  endtask : send
  task automatic complete_run();
    $display("compared %0d, mismatched %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : complete_run
  always @(negedge pclk) begin
    if (got === 1'b1) chk(cap, q.pop_front(), "output word");
  end
  initial begin
    repeat (20000) @(posedge pclk);
    fails++;
    complete_run();
  end
  initial begin
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    rdc(A_FMT, AOFMT_RST_FORMAT);
    rdc(A_SCR, AOFMT_RST_SCRAMBLE);
    rdc(A_PC, AOFMT_RST_PAT_CTRL);
    rdc(A_P0, AOFMT_RST_PAT0_LOW);
    rdc(A_PM, AOFMT_RST_PAT_MID);
    rdc(A_P1, AOFMT_RST_PAT1_HIGH);
    apb(1'b0, 12'h040, 16'h0000, 4'hF);
    chk(96'(err), 96'h1, "unmapped read");
    apb(1'b1, A_FMT + 12'h001, 16'h0000, 4'hF);
    chk(96'(err), 96'h1, "misaligned write");
    rdc(A_FMT, AOFMT_RST_FORMAT);
    $display("test registers done");
    for (int k = 0; k < 4; k++) begin
      {xr, tc} = k[1:0];
      apb(1'b1, A_FMT, {2'b00, tc, 4'h0, k[1:0], 7'h02}, 4'hF);
      apb(1'b1, A_SCR, {12'h000, xr, 3'h2}, 4'hF);
      chk(96'(gain_cal_on), 96'(k == 3), "gain flag");
      send(6);
    end
    $display("test coding done");
    t = rnd();
    w0 = t[23:0];
    t = rnd();
    w1 = t[23:0];
    apb(1'b1, A_P0, w0[15:0], 4'hF);
    apb(1'b1, A_PM, {w1[7:0], w0[23:16]}, 4'hF);
    apb(1'b1, A_P1, w1[23:8], 4'hF);
    apb(1'b1, A_P0, ~w0[15:0], 4'h2);
    w0[15:8] = ~w0[15:8];
    rdc(A_P0, w0[15:0]);
    rdc(A_PM, {w1[7:0], w0[23:16]});
    rdc(A_P1, w1[23:8]);
    rdc({2'b00, AOFMT_IDX_STAT_LOW, 2'b00}, w0[15:0]);
    rdc({2'b00, AOFMT_IDX_STAT_HIGH, 2'b00}, {5'h00, 3'b010, w0[23:16]});
    for (int k = 0; k < 5; k++) begin
      t = rnd();
      sel = (k == 4) ? 2'h2 : k[1:0];
      step = (k == 4) ? 4'hF : t[3:0];
      ins = 1'b1;
      ramp = '0;
      ph = 1'b0;
      apb(1'b1, A_PC, {8'h00, step, sel, 2'b10}, 4'hF);
      send(5);
      ins = 1'b0;
      apb(1'b1, A_PC, 16'h0000, 4'hF);
      send(1);
    end
    $display("test patterns done");
    chk(96'(q.size()), 96'h0, "words never delivered");
    complete_run();
  end
endmodule : testbench
